//--- core/orx_pkg.sv
// Package: encodings, field positions and reset values of the OR/rotate/return executor
package orx_pkg;
   localparam logic [7:0] ORX_OP_ORLIT = 8'h09;
   localparam logic [5:0] ORX_OP_ORFILE = 6'h04;
   localparam logic [5:0] ORX_OP_RLC = 6'h0d;
   localparam logic [14:0] ORX_OP_RET = 15'h0009;
   localparam int ORX_D_BIT = 9;
   localparam int ORX_A_BIT = 8;
   localparam int ORX_S_BIT = 0;
   localparam int ORX_FLAG_C = 0;
   localparam int ORX_FLAG_Z = 2;
   localparam int ORX_FLAG_N = 4;
   localparam logic [7:0] ORX_ACC_RST = 8'h00;
   localparam logic [7:0] ORX_FLAGS_RST = 8'h00;
   localparam logic [3:0] ORX_BANK_RST = 4'h0;
   localparam logic [3:0] ORX_ACCESS_BANK = 4'h0;
   localparam logic [1:0] ORX_Q1 = 2'h0;
   localparam logic [1:0] ORX_Q2 = 2'h1;
   localparam logic [1:0] ORX_Q3 = 2'h2;
   localparam logic [1:0] ORX_Q4 = 2'h3;
   typedef enum logic [1:0] {ORX_EXEC, ORX_FLUSH} orx_state_e;
endpackage : orx_pkg

//--- core/orx_exec.sv
// Executor for literal OR, file OR, rotate left through carry and return
//
// Overview of operation
// - Literal OR ORs the accumulator with the 8-bit immediate, writes the accumulator, sets N and Z only.
// - File OR ORs the accumulator with the addressed data byte and sets N and Z only.
// - Destination bit 0 sends the result to the accumulator, 1 writes it back to the file register.
// - Bank bit 0 forces the access bank, 1 takes the bank from the bank select register.
// - A one-cycle file instruction decodes in Q1, reads in Q2, processes in Q3, writes in Q4.
// - Return pops the call stack and loads the popped top into the program counter.
// - Return with shadow flag set restores accumulator, flags and bank select from shadows.
// - Return leaves the upper and high PC latches unaffected, and all flags too when the shadow flag is clear.
// - Rotate shifts the byte left, bit 7 into carry, old carry into bit 0, and sets C, N, Z.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module orx_exec
   import orx_pkg::*;
#(
   parameter int PC_W = 21
) (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic [1:0] qphase_in,
   input wire logic [15:0] instr_in,
   input wire logic instr_valid_in,
   input wire logic [7:0] file_rdata_in,
   input wire logic [PC_W-1:0] stack_top_in,
   input wire logic [7:0] acc_shadow_in,
   input wire logic [7:0] flags_shadow_in,
   input wire logic [3:0] bank_sel_shadow_in,
   output logic [11:0] file_addr_out,
   output logic file_rd_out,
   output logic file_wr_out,
   output logic [7:0] file_wdata_out,
   output logic stack_pop_out,
   output logic pc_load_out,
   output logic [PC_W-1:0] pc_value_out,
   output logic flush_out,
   output logic [7:0] acc_out,
   output logic [7:0] flags_out,
   output logic [3:0] bank_select_reg_out
);
   import orx_pkg::*;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   orx_state_e state_q, state_d;
   logic [7:0] acc_q, acc_d, flags_q, flags_d, operand_q, operand_d;
   logic [7:0] wdata_q, wdata_d, result;
   logic [3:0] bank_q, bank_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic wr_q, wr_d, pop_q, pop_d, load_q, load_d;
   logic is_orlit, is_orfile, is_rlc, is_ret, is_file, active;

   // A return blocks decode for one full cycle while the fetch refills
   assign active = instr_valid_in && (state_q == ORX_EXEC);
   assign is_orlit = active && (instr_in[15:8] == ORX_OP_ORLIT);
   assign is_orfile = active && (instr_in[15:10] == ORX_OP_ORFILE);
   assign is_rlc = active && (instr_in[15:10] == ORX_OP_RLC);
   assign is_ret = active && (instr_in[15:1] == ORX_OP_RET);
   assign is_file = is_orfile || is_rlc;

   // Bank: access bank when a is clear, else bank select register
   assign file_addr_out = {(instr_in[ORX_A_BIT] ? bank_q : ORX_ACCESS_BANK),
                           instr_in[7:0]};
   assign file_rd_out = is_file && (qphase_in == ORX_Q2);

   // Rotate takes the carry as it stood before Q3, so C updates at that same edge
   always_comb begin
      if (is_rlc) begin
         result = {operand_q[6:0], flags_q[ORX_FLAG_C]};
      end else if (is_orlit) begin
         result = acc_q | instr_in[7:0];
      end else begin
         result = acc_q | operand_q;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      acc_d = acc_q;
      flags_d = flags_q;
      bank_d = bank_q;
      operand_d = operand_q;
      wdata_d = wdata_q;
      pc_d = pc_q;
      wr_d = 1'b0;
      pop_d = 1'b0;
      load_d = 1'b0;
      case (state_q)
         ORX_EXEC: begin
            if ((is_file || is_orlit) && qphase_in == ORX_Q2) begin
               operand_d = file_rdata_in;
            end
            if ((is_file || is_orlit) && qphase_in == ORX_Q3) begin
               flags_d[ORX_FLAG_N] = result[7];
               flags_d[ORX_FLAG_Z] = (result == 8'h00);
               if (is_rlc) begin
                  flags_d[ORX_FLAG_C] = operand_q[7];
               end
               wdata_d = result;
            end
            if ((is_file || is_orlit) && qphase_in == ORX_Q4) begin
               if (is_orlit || !instr_in[ORX_D_BIT]) begin
                  acc_d = wdata_q;
               end else begin
                  wr_d = 1'b1;
               end
            end
            if (is_ret && qphase_in == ORX_Q4) begin
               pop_d = 1'b1;
               load_d = 1'b1;
               pc_d = stack_top_in;
               if (instr_in[ORX_S_BIT]) begin
                  acc_d = acc_shadow_in;
                  flags_d = flags_shadow_in;
                  bank_d = bank_sel_shadow_in;
               end
               state_d = ORX_FLUSH;
            end
         end
         ORX_FLUSH: begin
            // Second cycle of return: decode is held off, nothing is written
            if (qphase_in == ORX_Q4) begin
               state_d = ORX_EXEC;
            end
         end
         default: state_d = ORX_EXEC;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state_q <= ORX_EXEC;
         acc_q <= ORX_ACC_RST;
         flags_q <= ORX_FLAGS_RST;
         bank_q <= ORX_BANK_RST;
         operand_q <= 8'h00;
         wdata_q <= 8'h00;
         pc_q <= '0;
         wr_q <= 1'b0;
         pop_q <= 1'b0;
         load_q <= 1'b0;
      end else begin
         state_q <= state_d;
         acc_q <= acc_d;
         flags_q <= flags_d;
         bank_q <= bank_d;
         operand_q <= operand_d;
         wdata_q <= wdata_d;
         pc_q <= pc_d;
         wr_q <= wr_d;
         pop_q <= pop_d;
         load_q <= load_d;
      end
   end

   // PC latches are not ports of this block, so return never touches them
   assign file_wr_out = wr_q;
   assign file_wdata_out = wdata_q;
   assign stack_pop_out = pop_q;
   assign pc_load_out = load_q;
   assign pc_value_out = pc_q;
   assign flush_out = (state_q == ORX_FLUSH);
   assign acc_out = acc_q;
   assign flags_out = flags_q;
   assign bank_select_reg_out = bank_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   orlit_result_a: assert property (is_orlit && qphase_in == ORX_Q4 |=>
      acc_out == $past(wdata_q)) else $error("literal OR result not in accumulator");
   orfile_read_a: assert property (is_file && qphase_in == ORX_Q2 |-> file_rd_out ##1
      operand_q == $past(file_rdata_in)) else $error("file operand not read in Q2");
   dest_file_a: assert property (file_wr_out |-> $past(instr_in[ORX_D_BIT])
      && $past(qphase_in) == ORX_Q4) else $error("file write without d set");
   bank_access_a: assert property (is_file && !instr_in[ORX_A_BIT] |->
      file_addr_out[11:8] == ORX_ACCESS_BANK) else $error("access bank not forced");
   ret_pop_a: assert property (is_ret && qphase_in == ORX_Q4 |=>
      stack_pop_out && pc_load_out && pc_value_out == $past(stack_top_in))
      else $error("return did not pop stack");
   ret_noshadow_a: assert property (
      is_ret && !instr_in[ORX_S_BIT] && qphase_in == ORX_Q4 |=>
      $stable(acc_out) && $stable(flags_out) && $stable(bank_select_reg_out))
      else $error("registers changed without shadow flag");
   ret_flags_a: assert property (is_ret && !instr_in[ORX_S_BIT] |=>
      $stable(flags_out)) else $error("return changed flags");
   rlc_carry_a: assert property (is_rlc && qphase_in == ORX_Q3 |=>
      flags_out[ORX_FLAG_C] == $past(operand_q[7])) else $error("rotate carry wrong");
   ret_flush_a: assert property (pc_load_out |-> flush_out)
      else $error("no nop cycle after return");
   zero_flag_a: assert property (is_orfile && qphase_in == ORX_Q3 |=>
      flags_out[ORX_FLAG_Z] == ($past(result) == 8'h00)) else $error("zero flag wrong");
   neg_flag_a: assert property ((is_file || is_orlit) && qphase_in == ORX_Q3 |=>
      flags_out[ORX_FLAG_N] == file_wdata_out[7]) else $error("negative flag wrong");
   or_carry_a: assert property ((is_orfile || is_orlit) && qphase_in == ORX_Q3 |=>
      $stable(flags_out[ORX_FLAG_C])) else $error("OR changed carry");
   rlc_result_a: assert property (is_rlc && qphase_in == ORX_Q3 |=>
      file_wdata_out == {$past(operand_q[6:0]), $past(flags_out[ORX_FLAG_C])})
      else $error("rotate result wrong");
   acc_quarter_a: assert property ($changed(acc_out) |-> $past(qphase_in) == ORX_Q4)
      else $error("accumulator written outside Q4");
   flush_idle_a: assert property (flush_out |=> $stable(acc_out)
      && $stable(flags_out) && !file_wr_out) else $error("instruction executed in flush cycle");

   // ------------------------------------------------------------
   // Coverage
   // ------------------------------------------------------------
   ret_shadow_c: cover property (is_ret && instr_in[ORX_S_BIT] && qphase_in == ORX_Q4);
   ret_plain_c: cover property (is_ret && !instr_in[ORX_S_BIT] && qphase_in == ORX_Q4);
   orfile_wb_c: cover property (file_wr_out);
   rlc_c: cover property (is_rlc && qphase_in == ORX_Q4);
   orlit_c: cover property (is_orlit && qphase_in == ORX_Q4);
endmodule : orx_exec

//--- test/orx_exec_tb.sv
// Testbench for the OR, rotate and return executor
`timescale 1ns/1ps
module or_rotate_return_exec_tb_top;
   import orx_pkg::*;
   logic mclk_in = 1'b0, reset_in = 1'b1, instr_valid_in = 1'b0;
   logic [1:0] qphase_in = ORX_Q1;
   logic [15:0] instr_in = 16'h0000;
   logic [7:0] file_rdata_in = 8'h00, acc_shadow_in = 8'h9a, flags_shadow_in = 8'h01;
   logic [3:0] bank_sel_shadow_in = 4'h5;
   logic [20:0] stack_top_in = 21'h1abcde, pc_value_out;
   logic [11:0] file_addr_out;
   logic file_rd_out, file_wr_out, stack_pop_out, pc_load_out, flush_out;
   logic [7:0] file_wdata_out, acc_out, flags_out, e_acc, e_fl;
   logic [3:0] bank_select_reg_out, e_bank;
   int fail_count = 0, n_checks = 0, cycles = 0;

   orx_exec #(.PC_W(21)) orx_exec_i (.mclk_in(mclk_in), .reset_in(reset_in),
      .qphase_in(qphase_in), .instr_in(instr_in), .instr_valid_in(instr_valid_in),
      .file_rdata_in(file_rdata_in), .stack_top_in(stack_top_in),
      .acc_shadow_in(acc_shadow_in), .flags_shadow_in(flags_shadow_in),
      .bank_sel_shadow_in(bank_sel_shadow_in), .file_addr_out(file_addr_out),
      .file_rd_out(file_rd_out), .file_wr_out(file_wr_out), .file_wdata_out(file_wdata_out),
      .stack_pop_out(stack_pop_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
      .flush_out(flush_out), .acc_out(acc_out), .flags_out(flags_out),
      .bank_select_reg_out(bank_select_reg_out));

   always #50 mclk_in = ~mclk_in;

   // Quarter counter, plus a cap on run length
   always @(posedge mclk_in) begin
      qphase_in <= reset_in ? ORX_Q1 : qphase_in + 2'h1;
      cycles++;
      if (cycles == 1000) begin
         fail_count++;
         $display("[FAIL] %0t run timed out", $time);
         finish_test();
      end
   end

   task automatic finish_test();
      if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // ---------------------------------------------------------------
   // One instruction over Q1..Q4; ign marks a slot that must be dropped
   // A dropped slot starts at the next edge, so after a return it covers Q2 to Q4 of the flush cycle and the next Q1
   // ---------------------------------------------------------------
   task automatic exec(input logic [15:0] ins, input logic [7:0] rd, input logic ign);
      logic [7:0] res;
      logic lit, rlc, fop, wr, pop;
      lit = !ign && ins[15:8] == ORX_OP_ORLIT;
      rlc = !ign && ins[15:10] == ORX_OP_RLC;
      fop = rlc || (!ign && ins[15:10] == ORX_OP_ORFILE);
      pop = !ign && ins[15:1] == ORX_OP_RET;
      wr = fop && ins[ORX_D_BIT];
      res = rlc ? {rd[6:0], e_fl[ORX_FLAG_C]} : e_acc | (lit ? ins[7:0] : rd);
      if (ign) begin
         @(posedge mclk_in);
      end else begin
         do @(posedge mclk_in); while (qphase_in !== ORX_Q4);
      end
      instr_in <= ins;
      instr_valid_in <= 1'b1;
      file_rdata_in <= rd;
      @(posedge mclk_in);
      #1;
      if (!ign) chk(file_rd_out, fop);
      if (fop) chk(file_addr_out, {ins[ORX_A_BIT] ? e_bank : ORX_ACCESS_BANK, ins[7:0]});
      repeat (2) @(posedge mclk_in);
      #1;
      if (rlc) e_fl[ORX_FLAG_C] = rd[7];
      if (lit || fop) begin
         e_fl[ORX_FLAG_N] = res[7];
         e_fl[ORX_FLAG_Z] = (res == 8'h00);
      end
      chk(acc_out, e_acc);
      chk(flags_out, e_fl);
      @(posedge mclk_in);
      instr_valid_in <= 1'b0;
      #1;
      if ((lit || fop) && !wr) e_acc = res;
      if (pop && ins[ORX_S_BIT]) begin
         e_acc = acc_shadow_in;
         e_fl = flags_shadow_in;
         e_bank = bank_sel_shadow_in;
      end
      chk(file_wr_out, wr);
      if (wr) chk(file_wdata_out, res);
      chk(acc_out, e_acc);
      chk(flags_out, e_fl);
      chk(bank_select_reg_out, e_bank);
      chk(stack_pop_out, pop);
      chk(pc_load_out, pop);
      if (pop) chk(pc_value_out, stack_top_in);
      chk(flush_out, pop);
   endtask : exec

   initial begin
      repeat (8) @(posedge mclk_in);
      reset_in <= 1'b0;
      e_acc = ORX_ACC_RST;
      e_fl = ORX_FLAGS_RST;
      e_bank = ORX_BANK_RST;
      exec({ORX_OP_ORLIT, 8'h00}, 8'h5a, 1'b0);
      exec({ORX_OP_ORLIT, 8'h80}, 8'h00, 1'b0);
      exec({ORX_OP_RET, 1'b1}, 8'h00, 1'b0);
      exec({ORX_OP_ORLIT, 8'h7f}, 8'h00, 1'b1);
      exec({ORX_OP_ORFILE, 2'b01, 8'h13}, 8'h91, 1'b0);
      exec({ORX_OP_ORFILE, 2'b10, 8'h13}, 8'h00, 1'b0);
      exec({ORX_OP_RLC, 2'b11, 8'h22}, 8'he6, 1'b0);
      @(posedge mclk_in);
      acc_shadow_in <= 8'h00;
      flags_shadow_in <= 8'h00;
      bank_sel_shadow_in <= 4'ha;
      exec({ORX_OP_RET, 1'b1}, 8'h00, 1'b0);
      exec(16'hffff, 8'h00, 1'b1);
      exec({ORX_OP_RLC, 2'b00, 8'h40}, 8'h80, 1'b0);
      @(posedge mclk_in);
      acc_shadow_in <= 8'h55;
      flags_shadow_in <= 8'h15;
      bank_sel_shadow_in <= 4'h3;
      stack_top_in <= 21'h012345;
      exec({ORX_OP_RET, 1'b0}, 8'h00, 1'b0);
      exec({ORX_OP_RLC, 2'b11, 8'h01}, 8'h00, 1'b1);
      exec(16'hffff, 8'h00, 1'b1);
      finish_test();
   end
endmodule : or_rotate_return_exec_tb_top
